// *** core/tmr_pkg.sv ***
// package of constants and types for the timer output and global control
package tmr_pkg;

	// ****************************************************
	// register map and bus
	// ****************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CNT_LO = 8'h10;
	localparam logic [7:0] OFS_CNT_HI = 8'h14;
	localparam logic [7:0] OFS_PRD_LO = 8'h18;
	localparam logic [7:0] OFS_PRD_HI = 8'h1C;
	localparam logic [7:0] OFS_CTL = 8'h20;
	localparam logic [7:0] OFS_GCTL = 8'h24;

	// ****************************************************
	// timer_control field positions
	// ****************************************************
	localparam int CTL_STAT = 0;
	localparam int CTL_OINV = 1;
	localparam int CTL_IINV = 2;
	localparam int CTL_CP = 3;
	localparam int CTL_PWID = 4;
	localparam int CTL_ENA_LO = 6;
	localparam int CTL_CLK_SRC = 8;
	localparam int CTL_ENA_HI = 22;

	// ****************************************************
	// timer_global_control field positions
	// ****************************************************
	localparam int GCTL_RUN_LO = 0;
	localparam int GCTL_RUN_HI = 1;
	localparam int GCTL_MODE = 2;
	localparam int GCTL_PLUS = 4;
	localparam int GCTL_PLIM = 8;
	localparam int GCTL_PCNT = 12;

	// ****************************************************
	// encodings and reset values
	// ****************************************************
	localparam logic [1:0] MODE_GP64 = 2'h0;
	localparam logic [1:0] MODE_DUAL_UNCH = 2'h1;
	localparam logic [1:0] MODE_WDOG = 2'h2;
	localparam logic [1:0] MODE_DUAL_CHAIN = 2'h3;
	localparam logic [1:0] ENA_OFF = 2'h0;
	localparam logic [1:0] ENA_ONCE = 2'h1;
	localparam logic [1:0] ENA_CONT = 2'h2;
	localparam logic [1:0] ENA_RELOAD = 2'h3;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_NIB = 4'h0;
	localparam logic [1:0] RST_PAIR = 2'h0;

	// register bus request from software
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tmr_bus_s;

	// settings that shape the output waveform
	typedef struct packed {
		logic clockMode;
		logic outInvert;
		logic [1:0] pulseWidth;
	} tmr_shape_s;

endpackage : tmr_pkg

// *** core/tmr_sync.sv ***
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module tmr_sync (
	input wire logic clock,
	input wire logic resetn,
	input wire logic pinIn,
	output logic syncOut
);
	import tmr_pkg::*;

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_d = pinIn;
		sync_d = meta_q;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign syncOut = sync_q;

endmodule : tmr_sync
`default_nettype wire

// *** core/tmr_out_shaper.sv ***
// output waveform shaper: pulse or clock mode, then polarity
`timescale 1ns/1ps
`default_nettype none
module tmr_out_shaper (
	input wire logic clock,
	input wire logic resetn,
	input wire tmr_pkg::tmr_shape_s shape,
	input wire logic hitEvt,
	input wire logic zeroEvt,
	output logic status,
	output logic pinOut
);
	import tmr_pkg::*;

	typedef enum logic [1:0] {SH_IDLE, SH_PULSE, SH_CLOCK} tmr_shape_e;

	tmr_shape_e state_q;
	tmr_shape_e state_d;
	logic [1:0] left_q;
	logic [1:0] left_d;
	logic stat_q;
	logic stat_d;
	logic pin_q;
	logic pin_d;

	// next state of the waveform; pulse holds pwid+1 cycles
	always_comb
	begin
		state_d = state_q;
		left_d = left_q;
		stat_d = stat_q;
		case (state_q)
			SH_IDLE:
			begin
				stat_d = 1'b0;
				if (shape.clockMode)
					state_d = SH_CLOCK;
				else if (hitEvt)
				begin
					state_d = SH_PULSE;
					stat_d = 1'b1;
					left_d = shape.pulseWidth;
				end
			end
			SH_PULSE:
			begin
				if (left_q == 2'h0)
				begin
					state_d = SH_IDLE;
					stat_d = 1'b0;
				end
				else
					left_d = left_q - 2'h1;
			end
			SH_CLOCK:
			begin
				if (!shape.clockMode)
				begin
					state_d = SH_IDLE;
					stat_d = 1'b0;
				end
				else if (zeroEvt)
					stat_d = !stat_q;
			end
			default:
			begin
				state_d = SH_IDLE;
				stat_d = 1'b0;
			end
		endcase
		// polarity applied after shaping so status stays true
		pin_d = stat_q ^ shape.outInvert;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_q <= SH_IDLE;
			left_q <= RST_PAIR;
			stat_q <= 1'b0;
			pin_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			left_q <= left_d;
			stat_q <= stat_d;
			pin_q <= pin_d;
		end
	end

	assign status = stat_q;
	assign pinOut = pin_q;

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	logic [2:0] runLen_q;
	always_ff @(posedge clock)
	begin
		if (!resetn)
			runLen_q <= 3'h0;
		else if (state_q == SH_PULSE)
			runLen_q <= runLen_q + 3'h1;
		else
			runLen_q <= 3'h0;
	end

	a_pulse_width_len: assert property (
		(state_q == SH_PULSE) && (left_q == 2'h0) |->
		runLen_q == {1'b0, $past(shape.pulseWidth, 1)} ||
		$past(shape.pulseWidth) != $past(shape.pulseWidth, 2)
	) else $error("pulse length differs from width field");

	a_clock_toggle: assert property (
		state_q == SH_CLOCK && shape.clockMode && zeroEvt |=>
		stat_q != $past(stat_q)
	) else $error("clock mode missed a toggle at zero");

	a_pin_polarity: assert property (
		$stable(shape.outInvert) [*2] |->
		pin_q == ($past(stat_q) ^ shape.outInvert)
	) else $error("pin level does not follow status and polarity");

	c_pulse_seen: cover property (state_q == SH_PULSE ##1 state_q == SH_IDLE);
	c_clock_seen: cover property (state_q == SH_CLOCK && zeroEvt);

endmodule : tmr_out_shaper
`default_nettype wire

// *** core/tmr_top.sv ***
// timer core: counters, prescaler, global control and register port
// Summary of operation
// - pulse mode: output goes active after counter reaches period
// - clock mode: output toggles each time the counter reaches zero
// - input invert acts only with external clock source selected
// - output invert flips the pin level; clear leaves it uninverted
// - status bit drives the timer output pin
// - upper prescale count steps every clock while upper half enabled in dual unchained mode
// - upper counter steps the cycle after prescale count hits limit
// - one-shot upper half stops when counter equals period
// - continuous upper half returns to zero after matching period
// - extended features usable only with the feature enable set
// - mode zero runs both halves as one 64-bit timer
// - mode field and both run bits live in global control
// - modes 1, 2, 3: dual unchained, watchdog, dual chained
// - run bit low holds a half in reset; locked while watchdog active
// - pulse stays active one to four clocks per width field
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
	input wire logic clock,
	input wire logic resetn,
	input wire tmr_pkg::tmr_bus_s busReq,
	output logic [31:0] rdData,
	input wire logic timerInPinLo,
	output logic timerOutPinLo
);
	import tmr_pkg::*;

	// wide modes chain both halves into one 64-bit count
	function automatic logic isWide(input logic [1:0] m);
		isWide = (m == MODE_GP64) || (m == MODE_WDOG);
	endfunction : isWide

	function automatic logic wrAt(input tmr_bus_s b, input logic [7:0] a);
		wrAt = b.wr && (b.addr == a);
	endfunction : wrAt

	// ****************************************************
	// configuration registers
	// ****************************************************
	logic outInv_q, outInv_d, inInv_q, inInv_d, cpSel_q, cpSel_d;
	logic clock_source_select_q, clock_source_select_d, runLo_q, runLo_d, runHi_q, runHi_d;
	logic extended_features_enable_q, extended_features_enable_d;
	logic [1:0] pwid_q, pwid_d, enaLo_q, enaLo_d, enaHi_q, enaHi_d;
	logic [1:0] mode_q, mode_d;
	logic [3:0] psc_q, psc_d;
	logic [31:0] prdLo_q, prdLo_d, prdHi_q, prdHi_d;
	logic wdogActive;

	// watchdog active freezes the run bits against writes
	always_comb
	begin
		outInv_d = outInv_q;
		inInv_d = inInv_q;
		cpSel_d = cpSel_q;
		pwid_d = pwid_q;
		enaLo_d = enaLo_q;
		clock_source_select_d = clock_source_select_q;
		enaHi_d = enaHi_q;
		runLo_d = runLo_q;
		runHi_d = runHi_q;
		mode_d = mode_q;
		extended_features_enable_d = extended_features_enable_q;
		psc_d = psc_q;
		prdLo_d = prdLo_q;
		prdHi_d = prdHi_q;
		wdogActive = (mode_q == MODE_WDOG) && runLo_q && runHi_q;
		if (wrAt(busReq, OFS_CTL))
		begin
			outInv_d = busReq.wdata[CTL_OINV];
			inInv_d = busReq.wdata[CTL_IINV];
			cpSel_d = busReq.wdata[CTL_CP];
			pwid_d = busReq.wdata[CTL_PWID +: 2];
			enaLo_d = busReq.wdata[CTL_ENA_LO +: 2];
			clock_source_select_d = busReq.wdata[CTL_CLK_SRC];
			enaHi_d = busReq.wdata[CTL_ENA_HI +: 2];
		end
		if (wrAt(busReq, OFS_GCTL))
		begin
			mode_d = busReq.wdata[GCTL_MODE +: 2];
			extended_features_enable_d = busReq.wdata[GCTL_PLUS];
			psc_d = busReq.wdata[GCTL_PLIM +: 4];
			if (!wdogActive)
			begin
				runLo_d = busReq.wdata[GCTL_RUN_LO];
				runHi_d = busReq.wdata[GCTL_RUN_HI];
			end
		end
		if (wrAt(busReq, OFS_PRD_LO))
			prdLo_d = busReq.wdata;
		if (wrAt(busReq, OFS_PRD_HI))
			prdHi_d = busReq.wdata;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			outInv_q <= 1'b0;
			inInv_q <= 1'b0;
			cpSel_q <= 1'b0;
			pwid_q <= RST_PAIR;
			enaLo_q <= ENA_OFF;
			clock_source_select_q <= 1'b0;
			enaHi_q <= ENA_OFF;
			runLo_q <= 1'b0;
			runHi_q <= 1'b0;
			mode_q <= MODE_GP64;
			extended_features_enable_q <= 1'b0;
			psc_q <= RST_NIB;
			prdLo_q <= RST_WORD;
			prdHi_q <= RST_WORD;
		end
		else
		begin
			outInv_q <= outInv_d;
			inInv_q <= inInv_d;
			cpSel_q <= cpSel_d;
			pwid_q <= pwid_d;
			enaLo_q <= enaLo_d;
			clock_source_select_q <= clock_source_select_d;
			enaHi_q <= enaHi_d;
			runLo_q <= runLo_d;
			runHi_q <= runHi_d;
			mode_q <= mode_d;
			extended_features_enable_q <= extended_features_enable_d;
			psc_q <= psc_d;
			prdLo_q <= prdLo_d;
			prdHi_q <= prdHi_d;
		end
	end

	// ****************************************************
	// external clock input
	// ****************************************************
	logic pinSync, extLvl, extPrev_q, extPrev_d;

	tmr_sync u_sync (
		.clock(clock),
		.resetn(resetn),
		.pinIn(timerInPinLo),
		.syncOut(pinSync)
	);

	// inversion is an extended feature and needs the external source
	always_comb
	begin
		extLvl = pinSync ^ (inInv_q && clock_source_select_q && extended_features_enable_q);
		extPrev_d = extLvl;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			extPrev_q <= 1'b0;
		else
			extPrev_q <= extPrev_d;
	end

	// ****************************************************
	// counters and prescaler
	// ****************************************************
	logic [31:0] cntLo_q, cntLo_d, cntHi_q, cntHi_d;
	logic [3:0] tddr_q, tddr_d;
	logic hiStep_q, hiStep_d, hitEvt_q, hitEvt_d, zeroEvt_q, zeroEvt_d;
	logic wide, loSrc, loMatch, hiMatch, loTick, hiTick, pscRun;
	logic [63:0] cnt64, nxt64;

	// lower half or 64-bit count; upper half by prescale or chain
	always_comb
	begin
		wide = isWide(mode_q);
		cnt64 = {cntHi_q, cntLo_q};
		loSrc = clock_source_select_q ? (extLvl && !extPrev_q) : 1'b1;
		loMatch = wide ? (cnt64 == {prdHi_q, prdLo_q}) : (cntLo_q == prdLo_q);
		hiMatch = cntHi_q == prdHi_q;
		loTick = runLo_q && (enaLo_q != ENA_OFF) && loSrc &&
			!(enaLo_q == ENA_ONCE && loMatch) && (!wide || runHi_q);
		pscRun = runHi_q && (enaHi_q != ENA_OFF) && (mode_q == MODE_DUAL_UNCH);
		hiStep_d = pscRun && (tddr_q == psc_q);
		if (!pscRun)
			tddr_d = runHi_q ? tddr_q : RST_NIB;
		else if (tddr_q == psc_q)
			tddr_d = RST_NIB;
		else
			tddr_d = tddr_q + 4'h1;
		hiTick = !wide && runHi_q && (enaHi_q != ENA_OFF) &&
			!(enaHi_q == ENA_ONCE && hiMatch) &&
			((mode_q == MODE_DUAL_CHAIN) ? (loTick && loMatch) : hiStep_q);
		nxt64 = loMatch ? 64'h0 : cnt64 + 64'h1;
		cntLo_d = cntLo_q;
		cntHi_d = cntHi_q;
		if (wide && loTick)
			{cntHi_d, cntLo_d} = nxt64;
		if (!wide && loTick)
			cntLo_d = loMatch ? 32'h0 : cntLo_q + 32'h1;
		if (hiTick)
			cntHi_d = hiMatch ? 32'h0 : cntHi_q + 32'h1;
		if (wrAt(busReq, OFS_CNT_LO))
			cntLo_d = busReq.wdata;
		if (wrAt(busReq, OFS_CNT_HI))
			cntHi_d = busReq.wdata;
		if (!runLo_q)
			cntLo_d = 32'h0;
		if (!runHi_q)
			cntHi_d = 32'h0;
		hitEvt_d = loTick && (wide ? (nxt64 == {prdHi_q, prdLo_q}) :
			(cntLo_d == prdLo_q));
		zeroEvt_d = loTick && loMatch;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			cntLo_q <= RST_WORD;
			cntHi_q <= RST_WORD;
			tddr_q <= RST_NIB;
			hiStep_q <= 1'b0;
			hitEvt_q <= 1'b0;
			zeroEvt_q <= 1'b0;
		end
		else
		begin
			cntLo_q <= cntLo_d;
			cntHi_q <= cntHi_d;
			tddr_q <= tddr_d;
			hiStep_q <= hiStep_d;
			hitEvt_q <= hitEvt_d;
			zeroEvt_q <= zeroEvt_d;
		end
	end

	// ****************************************************
	// output shaping
	// ****************************************************
	tmr_shape_s shape;
	logic statBit, pinBit;

	// pulse width forced to the narrowest when extended features are off
	assign shape = '{clockMode: cpSel_q, outInvert: outInv_q,
		pulseWidth: (extended_features_enable_q ? pwid_q : RST_PAIR)};

	tmr_out_shaper u_shape (
		.clock(clock),
		.resetn(resetn),
		.shape(shape),
		.hitEvt(hitEvt_q),
		.zeroEvt(zeroEvt_q),
		.status(statBit),
		.pinOut(pinBit)
	);

	assign timerOutPinLo = pinBit;

	// ****************************************************
	// read port
	// ****************************************************
	logic [31:0] rd_q, rd_d, ctlWord, gctlWord;

	// read data appear only in the cycle after the strobe
	always_comb
	begin
		ctlWord = 32'h0;
		ctlWord[CTL_STAT] = statBit;
		ctlWord[CTL_OINV] = outInv_q;
		ctlWord[CTL_IINV] = inInv_q;
		ctlWord[CTL_CP] = cpSel_q;
		ctlWord[CTL_PWID +: 2] = pwid_q;
		ctlWord[CTL_ENA_LO +: 2] = enaLo_q;
		ctlWord[CTL_CLK_SRC] = clock_source_select_q;
		ctlWord[CTL_ENA_HI +: 2] = enaHi_q;
		gctlWord = 32'h0;
		gctlWord[GCTL_RUN_LO] = runLo_q;
		gctlWord[GCTL_RUN_HI] = runHi_q;
		gctlWord[GCTL_MODE +: 2] = mode_q;
		gctlWord[GCTL_PLUS] = extended_features_enable_q;
		gctlWord[GCTL_PLIM +: 4] = psc_q;
		gctlWord[GCTL_PCNT +: 4] = tddr_q;
		rd_d = 32'h0;
		if (busReq.rd)
		begin
			case (busReq.addr)
				OFS_CNT_LO: rd_d = cntLo_q;
				OFS_CNT_HI: rd_d = cntHi_q;
				OFS_PRD_LO: rd_d = prdLo_q;
				OFS_PRD_HI: rd_d = prdHi_q;
				OFS_CTL: rd_d = ctlWord;
				OFS_GCTL: rd_d = gctlWord;
				default: rd_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			rd_q <= RST_WORD;
		else
			rd_q <= rd_d;
	end

	assign rdData = rd_q;

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_prescale_step_hi: assert property (
		pscRun && tddr_q == psc_q && !busReq.wr && enaHi_q != ENA_ONCE
		##1 pscRun && !hiMatch && !busReq.wr |=>
		cntHi_q == $past(cntHi_q) + 32'h1
	) else $error("upper counter did not step after prescale match");

	a_prescale_count: assert property (
		pscRun && tddr_q != psc_q && !busReq.wr |=> tddr_q == $past(tddr_q) + 4'h1
	) else $error("prescale count did not advance");

	a_cont_wrap_hi: assert property (
		hiTick && hiMatch && enaHi_q == ENA_CONT && !busReq.wr && runHi_q
		|=> cntHi_q == 32'h0
	) else $error("upper counter did not wrap after period");

	a_once_stop_hi: assert property (
		!wide && runHi_q && enaHi_q == ENA_ONCE && hiMatch && !busReq.wr
		|=> $stable(cntHi_q)
	) else $error("one-shot upper half kept counting");

	a_run_reset_lo: assert property (
		!runLo_q [*2] |-> cntLo_q == 32'h0
	) else $error("lower half counts while held in reset");

	a_wdog_lock_run: assert property (
		wdogActive && wrAt(busReq, OFS_GCTL) |=> runLo_q && runHi_q
	) else $error("run bits changed while watchdog active");

	a_read_gctl_word: assert property (
		busReq.rd && busReq.addr == OFS_GCTL |=> rdData == $past(gctlWord)
	) else $error("global control readback wrong");

	c_wide_hit: cover property (wide && hitEvt_q);
	c_chain_step: cover property (mode_q == MODE_DUAL_CHAIN && hiTick);

endmodule : tmr_top
`default_nettype wire

// *** bench/tmr_pin_partner.sv ***
// partner model: external logic that feeds and watches the timer pins
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_partner (
	input wire logic clock,
	input wire logic pinOut,
	input wire logic idleLevel,
	output logic extPin,
	output int pulseCount,
	output int pulseLen
);
	int runLen = 0;
	int cntSeen = 0;
	int lenSeen = 0;
	// the external pin idles high so that a falling step can be
	// offered to the input inversion logic
	logic pinLvl = 1'b1;

	// ****************************************************
	// pin watcher and pin driver
	// ****************************************************
	// one driver per output: the watcher and the task own the variables
	assign pulseCount = cntSeen;
	assign pulseLen = lenSeen;
	assign extPin = pinLvl;

	// length of each excursion away from idle, in whole clocks;
	// a reset in mid-excursion leaves a short length that the next
	// complete excursion overwrites
	always @(posedge clock)
	begin
		if (pinOut !== idleLevel)
			runLen <= runLen + 1;
		else if (runLen != 0)
		begin
			lenSeen <= runLen;
			cntSeen <= cntSeen + 1;
			runLen <= 0;
		end
	end

	// the level only moves just after an edge, like a real driver
	task automatic set_pin(input logic lvl);
		@(posedge clock);
		pinLvl <= lvl;
	endtask : set_pin
endmodule : tmr_pin_partner
`default_nettype wire

// *** bench/timer_output_and_global_control_tb.sv ***
// self-checking testbench for the timer output and global control
`timescale 1ns/1ps
`default_nettype none
module timer_output_and_global_control_tb;
	import tmr_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	tmr_bus_s busReq = '0;
	logic [31:0] rdData;
	logic pinIn;
	logic pinOut;
	logic idleLevel = 1'b0;
	int pulseCount;
	int pulseLen;
	int errCount = 0;
	int testsRun = 0;
	logic [31:0] v;
	logic [31:0] a;
	logic [31:0] b;

	// ****************************************************
	// clock, design and partner
	// ****************************************************
	always #10 clock = ~clock;

	tmr_top DUT (
		.clock(clock),
		.resetn(resetn),
		.busReq(busReq),
		.rdData(rdData),
		.timerInPinLo(pinIn),
		.timerOutPinLo(pinOut)
	);

	tmr_pin_partner peer (
		.clock(clock),
		.pinOut(pinOut),
		.idleLevel(idleLevel),
		.extPin(pinIn),
		.pulseCount(pulseCount),
		.pulseLen(pulseLen)
	);

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		testsRun++;
		if (got !== exp)
		begin
			errCount++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// one-cycle write strobe beside address and data
	task automatic bus_wr(input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clock);
		busReq.addr <= adr;
		busReq.wdata <= dat;
		busReq.wr <= 1'b1;
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask : bus_wr

	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] adr, output logic [31:0] dat);
		@(posedge clock);
		busReq.addr <= adr;
		busReq.rd <= 1'b1;
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1 dat = rdData;
	endtask : bus_rd

	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
	endtask : cycles

	// a short reset in mid-run restarts every scenario from zero
	task automatic do_reset();
		@(posedge clock);
		resetn <= 1'b0;
		cycles(2);
		resetn <= 1'b1;
	endtask : do_reset

	task automatic wait_pin(input logic lvl);
		int i;
		for (i = 0; i < 300 && pinOut !== lvl; i++)
			@(posedge clock);
		if (pinOut !== lvl)
		begin
			errCount++;
			$display("Error at %0t: output pin stuck", $time);
			complete_run();
		end
	endtask : wait_pin

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic test_reset_map();
		bus_rd(OFS_CTL, v);
		check(v, 32'h0, "control after reset");
		check({31'h0, pinOut}, 32'h0, "pin after reset");
		bus_wr(8'hFC, 32'hFFFF_FFFF);
		bus_rd(8'hFC, v);
		check(v, 32'h0, "unmapped read");
		bus_wr(OFS_GCTL, 32'h0000_0003);
		bus_rd(OFS_GCTL, v);
		check(v, 32'h0000_0003, "run bits");
	endtask : test_reset_map

	// mode codes one to three read back; watchdog state locks the run bits
	task automatic test_modes();
		for (int m = 1; m < 4; m++)
		begin
			bus_wr(OFS_GCTL, 32'(m << 2));
			bus_rd(OFS_GCTL, v);
			check(v, 32'(m << 2), "mode field");
		end
		bus_wr(OFS_GCTL, {28'h0, MODE_WDOG, 2'h3});
		bus_wr(OFS_GCTL, {28'h0, MODE_WDOG, 2'h0});
		bus_rd(OFS_GCTL, v);
		check(v, 32'h0000_000B, "watchdog lock");
		do_reset();
	endtask : test_modes

	// internal clock ignores input inversion; run bit low clears
	task automatic test_run_hold();
		do_reset();
		bus_wr(OFS_PRD_LO, 32'h0000_00FF);
		bus_wr(OFS_GCTL, 32'h0000_0015);
		bus_wr(OFS_CTL, 32'h0000_0084);
		cycles(5);
		bus_rd(OFS_CNT_LO, a);
		bus_rd(OFS_CNT_LO, b);
		check(b - a, 32'h2, "internal count rate");
		bus_wr(OFS_GCTL, 32'h0000_0014);
		bus_rd(OFS_CNT_LO, v);
		check(v, 32'h0, "half held in reset");
	endtask : test_run_hold

	// one falling step of the external pin, counted or not
	task automatic ext_case(input logic [31:0] gc, input logic [31:0] tc,
		input logic [31:0] exp);
		do_reset();
		bus_wr(OFS_PRD_LO, 32'h0000_0064);
		bus_wr(OFS_GCTL, gc);
		bus_wr(OFS_CTL, tc);
		cycles(4);
		peer.set_pin(1'b0);
		cycles(6);
		bus_rd(OFS_CNT_LO, v);
		check(v, exp, "external ticks");
		peer.set_pin(1'b1);
		cycles(6);
	endtask : ext_case

	// pulse mode, period of ten clocks, width measured on the pin
	task automatic pulse_case(input logic [31:0] gc, input logic [1:0] pw,
		input int exp);
		int c0;
		do_reset();
		idleLevel <= 1'b0;
		bus_wr(OFS_PRD_LO, 32'h0000_0009);
		bus_wr(OFS_GCTL, gc);
		c0 = pulseCount;
		bus_wr(OFS_CTL, {26'h0, pw, 4'h0} | 32'h0000_0080);
		cycles(40);
		check(32'(pulseLen), 32'(exp), "pulse width");
		check(32'(pulseCount - c0 >= 3), 32'h1, "pulse repeats");
	endtask : pulse_case

	// clock mode, halves of ten clocks, optional output inversion
	task automatic clock_case(input logic inv);
		do_reset();
		idleLevel <= inv;
		bus_wr(OFS_PRD_LO, 32'h0000_0009);
		bus_wr(OFS_GCTL, 32'h0000_0013);
		bus_wr(OFS_CTL, {30'h0, inv, 1'b0} | 32'h0000_0088);
		// polarity reaches the pin two edges on, long before the first zero
		cycles(2);
		check({31'h0, pinOut}, {31'h0, inv}, "idle level");
		wait_pin(~inv);
		cycles(2);
		bus_rd(OFS_CTL, v);
		check(v, {30'h0, inv, 1'b1} | 32'h0000_0088, "status");
		cycles(40);
		check(32'(pulseLen), 32'hA, "half period");
	endtask : clock_case

	// upper half in dual unchained mode behind the prescaler
	task automatic test_prescale();
		do_reset();
		bus_wr(OFS_PRD_HI, 32'h0000_FFFF);
		bus_wr(OFS_GCTL, 32'h0000_0306);
		bus_wr(OFS_CTL, 32'h0080_0000);
		cycles(10);
		bus_rd(OFS_CNT_HI, a);
		cycles(14);
		bus_rd(OFS_CNT_HI, b);
		check(b - a, 32'h4, "prescaled rate");
		bus_rd(OFS_GCTL, v);
		check(32'({v[31:16], v[11:0]}), 32'h306, "other fields");
		check(32'(v[15:12] <= 4'h3), 32'h1, "prescale count bound");
		bus_wr(OFS_GCTL, 32'h0000_0F06);
		bus_rd(OFS_GCTL, a);
		bus_rd(OFS_GCTL, b);
		check(32'(4'(b[15:12] - a[15:12])), 32'h2, "count step");
	endtask : test_prescale

	task automatic test_upper_stop();
		do_reset();
		bus_wr(OFS_PRD_HI, 32'h0000_0005);
		bus_wr(OFS_GCTL, 32'h0000_0006);
		bus_wr(OFS_CTL, 32'h0040_0000);
		cycles(30);
		bus_rd(OFS_CNT_HI, v);
		check(v, 32'h5, "one-shot stop");
		bus_wr(OFS_CTL, 32'h0080_0000);
		cycles(3);
		bus_rd(OFS_CNT_HI, a);
		bus_rd(OFS_CNT_HI, b);
		check(32'(a < 6), 32'h1, "wrap bound");
		check(b, (a + 2) % 6, "wrap sequence");
	endtask : test_upper_stop

	// lower half carries into the upper half as one wide count, then
	// chained: the upper half steps once per lower wrap of four clocks
	task automatic test_wide();
		do_reset();
		bus_wr(OFS_PRD_HI, 32'h0000_00FF);
		bus_wr(OFS_GCTL, 32'h0000_0003);
		bus_wr(OFS_CNT_LO, 32'hFFFF_FFF0);
		bus_wr(OFS_CTL, 32'h0000_0080);
		cycles(30);
		bus_rd(OFS_CNT_HI, v);
		check(v, 32'h1, "wide carry");
		do_reset();
		bus_wr(OFS_PRD_LO, 32'h0000_0003);
		bus_wr(OFS_PRD_HI, 32'h0000_00FF);
		bus_wr(OFS_GCTL, 32'h0000_000F);
		bus_wr(OFS_CTL, 32'h0080_0080);
		cycles(20);
		bus_rd(OFS_CNT_HI, v);
		check(v, 32'h5, "chained carry");
	endtask : test_wide

	// ****************************************************
	// main sequence and hang guard
	// ****************************************************
	initial
	begin
		cycles(8);
		resetn <= 1'b1;
		test_reset_map();
		test_modes();
		test_run_hold();
		ext_case(32'h13, 32'h180, 32'h0);
		ext_case(32'h13, 32'h184, 32'h1);
		ext_case(32'h03, 32'h184, 32'h0);
		for (int p = 0; p < 4; p++)
			pulse_case(32'h13, 2'(p), p + 1);
		pulse_case(32'h03, 2'h3, 1);
		clock_case(1'b0);
		clock_case(1'b1);
		test_prescale();
		test_upper_stop();
		test_wide();
		complete_run();
	end

	// a run that outlives this bound is a hang
	initial
	begin
		cycles(100000);
		errCount++;
		$display("Error at %0t: run did not finish", $time);
		complete_run();
	end
endmodule : timer_output_and_global_control_tb
`default_nettype wire
